/* File: acpd_defs.vh */
// Constants for the audio port clock and pin direction block.
// Assumes a 32-bit classic Wishbone slave with byte addresses on adr_i.
//
// Notes on behaviour
// - Six pins each have their own programmable direction bit.
// - Frame sync, bit clock and high clock are generated even when pins are inputs.
// - Functional logic on the peripheral clock; auxiliary clock feeds the dividers.
// - An external clock on the high clock pin may replace the auxiliary clock.
// - Internal clocking: auxiliary clock through high divider, then bit divider.
// - Direction word 0x1c000000 drives the three transmit pins, receive pins are inputs.
// - High control 0x000080xx: auxiliary clock divided by field bits 0-11.
// - Bit control 0x0000002x: high divider output divided by field bits 0-4.
// - Direction word zero makes all transmit clock pins inputs.
// - High control zero: bit clock straight from pin, bit control ignored.
// - Direction word 0x14000000: transmit high clock input, frame sync and bit clock outputs.
// - High control 0x000000xx: high clock pin divided by bits 0-11 feeds bit divider.
`ifndef ACPD_DEFS_VH
`define ACPD_DEFS_VH

// Register byte offsets
`define ACPD_OFS_PIN_DIR      8'h00
`define ACPD_OFS_TX_HCLK_CTL  8'h04
`define ACPD_OFS_TX_BCLK_CTL  8'h08
`define ACPD_OFS_RX_HCLK_CTL  8'h0c
`define ACPD_OFS_RX_BCLK_CTL  8'h10
`define ACPD_OFS_STATUS       8'h14
`define ACPD_OFS_FRAME_CTL    8'h18

// Pin direction bit positions
`define ACPD_DIR_TX_FS        28
`define ACPD_DIR_TX_HCLK      27
`define ACPD_DIR_TX_BCLK      26
`define ACPD_DIR_RX_FS        31
`define ACPD_DIR_RX_HCLK      30
`define ACPD_DIR_RX_BCLK      29

// High clock control fields
`define ACPD_HCLK_INT_BIT     15
`define ACPD_HCLK_DIV_MSB     11
`define ACPD_HCLK_DIV_W       12

// Bit clock control fields
`define ACPD_BCLK_INT_BIT     5
`define ACPD_BCLK_DIV_MSB     4
`define ACPD_BCLK_DIV_W       5

// Frame control fields: frame length minus one, in bit clocks
`define ACPD_FRM_TX_LSB       0
`define ACPD_FRM_RX_LSB       16
`define ACPD_FRM_W            9

// Status fields
`define ACPD_STS_FAIL_LSB     0
`define ACPD_STS_PIN_LSB      8
`define ACPD_STS_BCLK_LSB     16
`define ACPD_STS_FS_LSB       18

// Reset values
`define ACPD_RST_PIN_DIR      32'h00000000
`define ACPD_RST_HCLK_CTL     16'h0000
`define ACPD_RST_BCLK_CTL     6'h00
`define ACPD_RST_FRAME        9'h01f

`endif

/* File: acpd_div.v */
// Tick-driven clock divider: counts input ticks, ratio is divisor plus one.
// Assumes tick_i is a one-cycle pulse on clk_i per source clock rising edge.
`timescale 1ns/100ps
module acpd_div #(
	parameter W = 12
) (
	// Clock and reset
	input  wire         clk_i,
	input  wire         rst_i,
	// Source and setting
	input  wire         tick_i,
	input  wire [W-1:0] div_i,
	// Divided clock
	output wire         tick_o,
	output wire         level_o
);

	reg  [W-1:0] cnt_reg;
	reg  [W-1:0] cnt_next;
	reg          tick_reg;
	reg          level_reg;
	wire [W:0]   half;

	// Ratio one keeps the level high; the tick stream still follows the source
	assign half = ({1'b0, div_i} + {{W{1'b0}}, 1'b1} + {{W{1'b0}}, 1'b1}) >> 1;

	always @*
	begin
		cnt_next = cnt_reg;
		if (tick_i)
		begin
			if (cnt_reg >= div_i)
				cnt_next = {W{1'b0}};
			else
				cnt_next = cnt_reg + {{(W-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_reg   <= {W{1'b0}};
			tick_reg  <= 1'b0;
			level_reg <= 1'b0;
		end
		else
		begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_i & (cnt_reg >= div_i);
			if (tick_i)
				level_reg <= ({1'b0, cnt_next} < half);
		end
	end

	assign tick_o  = tick_reg;
	assign level_o = level_reg;

endmodule

/* File: acpd_top.v */
// Clock generation and pin direction control for a two-section audio serial port.
// Assumes aux_clk_i and all pins are asynchronous to clk_i and much slower than it.
`timescale 1ns/100ps
`include "acpd_defs.vh"
module acpd_top (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire        wb_ack_o,
	// Auxiliary clock source
	input  wire        aux_clk_i,
	// Transmit frame sync pin
	input  wire        tx_frame_sync_pin_i,
	output wire        tx_frame_sync_pin_o,
	output wire        tx_frame_sync_pin_oe_n_o,
	// Transmit high clock pin
	input  wire        tx_high_clock_pin_i,
	output wire        tx_high_clock_pin_o,
	output wire        tx_high_clock_pin_oe_n_o,
	// Transmit bit clock pin
	input  wire        tx_bit_clock_pin_i,
	output wire        tx_bit_clock_pin_o,
	output wire        tx_bit_clock_pin_oe_n_o,
	// Receive frame sync pin
	input  wire        rx_frame_sync_pin_i,
	output wire        rx_frame_sync_pin_o,
	output wire        rx_frame_sync_pin_oe_n_o,
	// Receive high clock pin
	input  wire        rx_high_clock_pin_i,
	output wire        rx_high_clock_pin_o,
	output wire        rx_high_clock_pin_oe_n_o,
	// Receive bit clock pin
	input  wire        rx_bit_clock_pin_i,
	output wire        rx_bit_clock_pin_o,
	output wire        rx_bit_clock_pin_oe_n_o
);

	// Input index: 0 tx fs, 1 tx hclk, 2 tx bclk, 3 rx fs, 4 rx hclk, 5 rx bclk, 6 aux
	wire [6:0]  raw_in;
	reg  [6:0]  sync1_reg;
	reg  [6:0]  sync2_reg;
	reg  [6:0]  sync3_reg;
	reg  [6:0]  filt_reg;
	reg  [6:0]  filt_next;
	wire [6:0]  rise;

	reg  [31:0] pin_dir_reg;
	reg  [15:0] tx_hclk_ctl_reg;
	reg  [15:0] rx_hclk_ctl_reg;
	reg  [5:0]  tx_bclk_ctl_reg;
	reg  [5:0]  rx_bclk_ctl_reg;
	reg  [8:0]  tx_frame_reg;
	reg  [8:0]  rx_frame_reg;
	reg  [1:0]  fail_reg;
	reg  [31:0] dat_reg;
	reg  [31:0] dat_next;
	reg         ack_reg;
	reg  [5:0]  pin_out_reg;
	reg  [5:0]  pin_oe_n_reg;

	wire [31:0] hclk_ctl_pair;
	wire [11:0] bclk_ctl_pair;
	wire [17:0] frame_pair;
	wire [5:0]  dir_bits;
	wire [1:0]  hclk_lvl;
	wire [1:0]  bclk_lvl;
	wire [1:0]  fs_lvl;
	wire [1:0]  fail_set;
	wire        req;
	wire        wr;
	wire [31:0] wmask;
	wire [31:0] status_word;

	assign raw_in = {aux_clk_i, rx_bit_clock_pin_i, rx_high_clock_pin_i, rx_frame_sync_pin_i,
	                 tx_bit_clock_pin_i, tx_high_clock_pin_i, tx_frame_sync_pin_i};

	// A level counts only once the second and third stages agree
	always @*
	begin
		filt_next = filt_reg;
		if (sync2_reg == sync3_reg)
			filt_next = sync3_reg;
	end

	assign rise = filt_next & ~filt_reg;

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync1_reg <= 7'h00;
			sync2_reg <= 7'h00;
			sync3_reg <= 7'h00;
			filt_reg  <= 7'h00;
		end
		else
		begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			filt_reg  <= filt_next;
		end
	end

	assign hclk_ctl_pair = {rx_hclk_ctl_reg, tx_hclk_ctl_reg};
	assign bclk_ctl_pair = {rx_bclk_ctl_reg, tx_bclk_ctl_reg};
	assign frame_pair    = {rx_frame_reg, tx_frame_reg};
	// Direction bits in input index order
	assign dir_bits = {pin_dir_reg[`ACPD_DIR_RX_BCLK], pin_dir_reg[`ACPD_DIR_RX_HCLK],
	                   pin_dir_reg[`ACPD_DIR_RX_FS], pin_dir_reg[`ACPD_DIR_TX_BCLK],
	                   pin_dir_reg[`ACPD_DIR_TX_HCLK], pin_dir_reg[`ACPD_DIR_TX_FS]};

	// Section 0 is transmit, section 1 is receive
	genvar s;
	generate
		for (s = 0; s < 2; s = s + 1)
		begin : sec
			wire [15:0] hctl;
			wire [5:0]  bctl;
			wire [8:0]  flen;
			wire        hsrc_tick;
			wire        htick;
			wire        hlevel;
			wire        btick;
			wire        blevel;
			wire        direct;
			wire        ext_bclk;
			wire        bit_tick;
			reg  [8:0]  fcnt_reg;
			reg         fs_int_reg;

			assign hctl = hclk_ctl_pair[16*s+15:16*s];
			assign bctl = bclk_ctl_pair[6*s+5:6*s];
			assign flen = frame_pair[9*s+8:9*s];

			// Aux clock or high clock pin
			assign hsrc_tick = hctl[`ACPD_HCLK_INT_BIT] ? rise[6] : rise[3*s+1];

			acpd_div #(
				.W (`ACPD_HCLK_DIV_W)
			) u_hdiv (
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.tick_i  (hsrc_tick),
				.div_i   (hctl[`ACPD_HCLK_DIV_MSB:0]),
				.tick_o  (htick),
				.level_o (hlevel)
			);

			acpd_div #(
				.W (`ACPD_BCLK_DIV_W)
			) u_bdiv (
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.tick_i  (htick),
				.div_i   (bctl[`ACPD_BCLK_DIV_MSB:0]),
				.tick_o  (btick),
				.level_o (blevel)
			);

			// High control zero takes bit clock straight from pin
			assign direct   = (hctl == `ACPD_RST_HCLK_CTL);
			assign ext_bclk = direct | ~bctl[`ACPD_BCLK_INT_BIT];
			assign bit_tick = ext_bclk ? rise[3*s+2] : btick;

			// Frame sync generated whatever the pin direction
			always @(posedge clk_i)
			begin
				if (rst_i)
				begin
					fcnt_reg   <= 9'h000;
					fs_int_reg <= 1'b0;
				end
				else if (bit_tick)
				begin
					if (fcnt_reg >= flen)
						fcnt_reg <= 9'h000;
					else
						fcnt_reg <= fcnt_reg + 9'h001;
					fs_int_reg <= (fcnt_reg >= flen);
				end
			end

			assign hclk_lvl[s] = hlevel;
			assign bclk_lvl[s] = ext_bclk ? filt_reg[3*s+2] : blevel;
			assign fs_lvl[s]   = ext_bclk ? filt_reg[3*s] : fs_int_reg;
			// Foreign frame sync against an internal bit clock
			assign fail_set[s] = rise[3*s] & ~dir_bits[3*s] & ~ext_bclk;
		end
	endgenerate

	// Pin levels registered whatever the direction; enables follow direction bits
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pin_out_reg  <= 6'h00;
			pin_oe_n_reg <= 6'h3f;
		end
		else
		begin
			pin_out_reg  <= {bclk_lvl[1], hclk_lvl[1], fs_lvl[1], bclk_lvl[0], hclk_lvl[0], fs_lvl[0]};
			pin_oe_n_reg <= ~dir_bits;
		end
	end

	assign tx_frame_sync_pin_o      = pin_out_reg[0];
	assign tx_high_clock_pin_o      = pin_out_reg[1];
	assign tx_bit_clock_pin_o       = pin_out_reg[2];
	assign rx_frame_sync_pin_o      = pin_out_reg[3];
	assign rx_high_clock_pin_o      = pin_out_reg[4];
	assign rx_bit_clock_pin_o       = pin_out_reg[5];
	assign tx_frame_sync_pin_oe_n_o = pin_oe_n_reg[0];
	assign tx_high_clock_pin_oe_n_o = pin_oe_n_reg[1];
	assign tx_bit_clock_pin_oe_n_o  = pin_oe_n_reg[2];
	assign rx_frame_sync_pin_oe_n_o = pin_oe_n_reg[3];
	assign rx_high_clock_pin_oe_n_o = pin_oe_n_reg[4];
	assign rx_bit_clock_pin_oe_n_o  = pin_oe_n_reg[5];

	// One wait state; the ack drop also keeps a held request from acting twice
	assign req   = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign wr    = req & wb_we_i;
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	assign status_word = {12'h000, fs_lvl, bclk_lvl, 1'b0, filt_reg, 6'h00, fail_reg};

	always @*
	begin
		dat_next = 32'h00000000;
		case (wb_adr_i)
			`ACPD_OFS_PIN_DIR:     dat_next = pin_dir_reg;
			`ACPD_OFS_TX_HCLK_CTL: dat_next = {16'h0000, tx_hclk_ctl_reg};
			`ACPD_OFS_TX_BCLK_CTL: dat_next = {26'h0000000, tx_bclk_ctl_reg};
			`ACPD_OFS_RX_HCLK_CTL: dat_next = {16'h0000, rx_hclk_ctl_reg};
			`ACPD_OFS_RX_BCLK_CTL: dat_next = {26'h0000000, rx_bclk_ctl_reg};
			`ACPD_OFS_STATUS:      dat_next = status_word;
			`ACPD_OFS_FRAME_CTL:   dat_next = {7'h00, rx_frame_reg, 7'h00, tx_frame_reg};
			default:               dat_next = 32'h00000000;
		endcase
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pin_dir_reg     <= `ACPD_RST_PIN_DIR;
			tx_hclk_ctl_reg <= `ACPD_RST_HCLK_CTL;
			rx_hclk_ctl_reg <= `ACPD_RST_HCLK_CTL;
			tx_bclk_ctl_reg <= `ACPD_RST_BCLK_CTL;
			rx_bclk_ctl_reg <= `ACPD_RST_BCLK_CTL;
			tx_frame_reg    <= `ACPD_RST_FRAME;
			rx_frame_reg    <= `ACPD_RST_FRAME;
			fail_reg        <= 2'b00;
			dat_reg         <= 32'h00000000;
			ack_reg         <= 1'b0;
		end
		else
		begin
			ack_reg <= req;
			if (req)
				dat_reg <= dat_next;
			if (wr && wb_adr_i == `ACPD_OFS_PIN_DIR)
				pin_dir_reg <= (pin_dir_reg & ~wmask) | (wb_dat_i & wmask);
			if (wr && wb_adr_i == `ACPD_OFS_TX_HCLK_CTL)
			begin
				if (wb_sel_i[0])
					tx_hclk_ctl_reg[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					tx_hclk_ctl_reg[15:8] <= wb_dat_i[15:8] & 8'h8f;
			end
			if (wr && wb_adr_i == `ACPD_OFS_RX_HCLK_CTL)
			begin
				if (wb_sel_i[0])
					rx_hclk_ctl_reg[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					rx_hclk_ctl_reg[15:8] <= wb_dat_i[15:8] & 8'h8f;
			end
			if (wr && wb_adr_i == `ACPD_OFS_TX_BCLK_CTL && wb_sel_i[0])
				tx_bclk_ctl_reg <= wb_dat_i[5:0];
			if (wr && wb_adr_i == `ACPD_OFS_RX_BCLK_CTL && wb_sel_i[0])
				rx_bclk_ctl_reg <= wb_dat_i[5:0];
			if (wr && wb_adr_i == `ACPD_OFS_FRAME_CTL)
			begin
				if (wb_sel_i[0])
					tx_frame_reg[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					tx_frame_reg[8] <= wb_dat_i[8];
				if (wb_sel_i[2])
					rx_frame_reg[7:0] <= wb_dat_i[23:16];
				if (wb_sel_i[3])
					rx_frame_reg[8] <= wb_dat_i[24];
			end
			// Write one clears; a new failure wins over the clear
			if (wr && wb_adr_i == `ACPD_OFS_STATUS && wb_sel_i[0])
				fail_reg <= (fail_reg & ~wb_dat_i[1:0]) | fail_set;
			else
				fail_reg <= fail_reg | fail_set;
		end
	end

	assign wb_dat_o = dat_reg;
	assign wb_ack_o = ack_reg;

endmodule

/* File: acpd_props.sv */
// Checker for the pin direction block: bus handshake and pin enables.
// Assumes it is bound to acpd_top and sees only that module's ports.
`timescale 1ns/100ps
module acpd_props (
	input wire        clk_i,
	input wire        rst_i,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [7:0]  wb_adr_i,
	input wire [3:0]  wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        tx_frame_sync_pin_oe_n_o,
	input wire        tx_high_clock_pin_oe_n_o,
	input wire        tx_bit_clock_pin_oe_n_o,
	input wire        rx_bit_clock_pin_oe_n_o
);
	wire dir_wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 8'h00;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// Direction byte written with its byte lane enabled
	sequence s_dir_wr;
		dir_wr && wb_sel_i[3];
	endsequence
	a_ack_follows: assert property (s_take |=> wb_ack_o) else $error("ack missing after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("ack without strobe");
	a_unmapped_zero: assert property (s_take ##0 (!wb_we_i && wb_adr_i >= 8'h1c) |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_dir_tx_fs: assert property (s_dir_wr |-> ##2 tx_frame_sync_pin_oe_n_o == !$past(wb_dat_i[28], 2))
		else $error("tx frame sync enable wrong");
	a_dir_tx_hclk: assert property (s_dir_wr |-> ##2 tx_high_clock_pin_oe_n_o == !$past(wb_dat_i[27], 2))
		else $error("tx high clock enable wrong");
	a_dir_tx_bclk: assert property (s_dir_wr |-> ##2 tx_bit_clock_pin_oe_n_o == !$past(wb_dat_i[26], 2))
		else $error("tx bit clock enable wrong");
	a_dir_rx_bclk: assert property (s_dir_wr |-> ##2 rx_bit_clock_pin_oe_n_o == !$past(wb_dat_i[29], 2))
		else $error("rx bit clock enable wrong");
	a_oe_only_dir: assert property ($changed(tx_bit_clock_pin_oe_n_o) |-> $past(dir_wr, 2))
		else $error("enable moved without write");
	a_reset_undriven: assert property ($fell(rst_i) |-> tx_frame_sync_pin_oe_n_o && tx_high_clock_pin_oe_n_o)
		else $error("pin driven after reset");
endmodule
bind acpd_top acpd_props acpd_props_i (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.tx_frame_sync_pin_oe_n_o(tx_frame_sync_pin_oe_n_o), .tx_high_clock_pin_oe_n_o(tx_high_clock_pin_oe_n_o),
	.tx_bit_clock_pin_oe_n_o(tx_bit_clock_pin_oe_n_o), .rx_bit_clock_pin_oe_n_o(rx_bit_clock_pin_oe_n_o));

/* File: acpd_conv.sv */
// External converter model: master clock, bit clock and frame sync.
// Assumes board pull-downs, so released lines settle low.
`timescale 1ns/100ps
module acpd_conv (
	input  wire en_h_i,
	input  wire en_b_i,
	output reg  hclk_o,
	output reg  bclk_o,
	output reg  fs_o
);
	int n;
	initial
	begin
		hclk_o = 1'b0;
		bclk_o = 1'b0;
		fs_o = 1'b0;
		n = 0;
	end
	always #100 hclk_o = en_h_i ? ~hclk_o : 1'b0;
	// Frame sync rides on our own bit clock, one period high in eight
	always #120
	begin
		bclk_o = en_b_i ? ~bclk_o : 1'b0;
		fs_o = en_b_i && bclk_o ? n == 0 : fs_o && en_b_i;
		if (bclk_o)
			n = (n + 1) % 8;
	end
endmodule

/* File: acpd_top_bench.sv */
// Self-checking bench for the clock and pin direction block.
// Assumes the converter model stands on the transmit pins; receive pins are pulled low.
`timescale 1ns/100ps
module acpd_top_bench;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, aux_clk_i, en_h, en_b, last;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, seed, d;
	logic [63:0] q[$];
	logic [63:0] e;
	logic [31:0] qb[$];
	logic [5:0]  qp[$];
	logic        pin_due;
	int          fail_count, check_count, i, t_now, t_rise, n_rise;
	wire  [31:0] wb_dat_o;
	wire         wb_ack_o, cv_h, cv_b, cv_f, tfo, tfe, tho, the, tbo, tbe, rfo, rfe, rho, rhe, rbo, rbe;
	acpd_top acpd_top_i (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.aux_clk_i(aux_clk_i),
		.tx_frame_sync_pin_i(tfe ? cv_f : tfo), .tx_frame_sync_pin_o(tfo), .tx_frame_sync_pin_oe_n_o(tfe),
		.tx_high_clock_pin_i(the ? cv_h : tho), .tx_high_clock_pin_o(tho), .tx_high_clock_pin_oe_n_o(the),
		.tx_bit_clock_pin_i(tbe ? cv_b : tbo), .tx_bit_clock_pin_o(tbo), .tx_bit_clock_pin_oe_n_o(tbe),
		.rx_frame_sync_pin_i(!rfe & rfo), .rx_frame_sync_pin_o(rfo), .rx_frame_sync_pin_oe_n_o(rfe),
		.rx_high_clock_pin_i(!rhe & rho), .rx_high_clock_pin_o(rho), .rx_high_clock_pin_oe_n_o(rhe),
		.rx_bit_clock_pin_i(!rbe & rbo), .rx_bit_clock_pin_o(rbo), .rx_bit_clock_pin_oe_n_o(rbe));
	acpd_conv acpd_conv_i (.en_h_i(en_h), .en_b_i(en_b), .hclk_o(cv_h), .bclk_o(cv_b), .fs_o(cv_f));
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// Auxiliary source of 16 cycles, edges away from the clock's rising edge
	initial
	begin
		aux_clk_i = 1'b0;
		forever #80 aux_clk_i = ~aux_clk_i;
	end
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", check_count, fail_count);
			if (fail_count == 0 && check_count > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task cmp_read(input logic [31:0] exp, input logic [31:0] got);
		begin
			check_count++;
			if (got !== exp)
			begin
				fail_count++;
				$display("[ERR] read data expected %h seen %h", exp, got);
			end
		end
	endtask
	task cmp_pins(input logic [5:0] exp, input logic [5:0] got);
		begin
			check_count++;
			if (got !== exp)
			begin
				fail_count++;
				$display("[ERR] pin enables expected %h seen %h", exp, got);
			end
		end
	endtask
	task cmp_period(input logic [31:0] exp, input logic [31:0] got);
		begin
			check_count++;
			if (got !== exp)
			begin
				fail_count++;
				$display("[ERR] bit clock period expected %0d seen %0d", exp, got);
			end
		end
	endtask
	task wb(input logic we, input logic [7:0] a, input logic [31:0] dt, input logic [3:0] s);
		int k;
		begin
			wb_cyc_i <= 1'b1;
			wb_stb_i <= 1'b1;
			wb_we_i <= we;
			wb_adr_i <= a;
			wb_dat_i <= dt;
			wb_sel_i <= s;
			k = 0;
			@(posedge clk_i);
			while (wb_ack_o !== 1'b1 && k < 50)
			begin
				@(posedge clk_i);
				k++;
			end
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
			if (k == 50)
			begin
				fail_count++;
				complete_run();
			end
			@(posedge clk_i);
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		begin
			q.push_back({m, exp});
			wb(1'b0, a, $random(seed), 4'hf);
		end
	endtask
	// Notes the expected period; the watcher below measures it
	task per(input logic [31:0] exp);
		int k;
		begin
			qb.push_back(exp);
			k = 0;
			while (qb.size() > 0 && k < 4000)
			begin
				@(posedge clk_i);
				k++;
			end
			if (k == 4000)
			begin
				fail_count++;
				complete_run();
			end
		end
	endtask
	always @(posedge clk_i)
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
		begin
			e = q.pop_front();
			cmp_read(e[31:0], wb_dat_o & e[63:32]);
		end
	// Enables settle one cycle after the acknowledged direction write
	always @(posedge clk_i)
	begin
		if (pin_due === 1'b1)
			cmp_pins(qp.pop_front(), {rfe, rhe, rbe, tfe, the, tbe});
		pin_due = wb_ack_o === 1'b1 && wb_we_i === 1'b1 && wb_adr_i === 8'h00 && qp.size() > 0;
	end
	// First interval may follow a setting change, so the second is compared
	always @(posedge clk_i)
	begin
		t_now++;
		if (qb.size() == 0)
			n_rise = 0;
		else if (tbo === 1'b1 && last === 1'b0)
		begin
			if (n_rise == 2)
				cmp_period(qb.pop_front(), t_now - t_rise);
			t_rise = t_now;
			n_rise++;
		end
		last = tbo;
	end
	initial
	begin
		seed = 32'he627;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, en_h, en_b} = '0;
		rst_i = 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(8'h00, 32'h0, '1);
		rd(8'h04, 32'h0, '1);
		rd(8'h18, 32'h001f001f, '1);
		wb(1'b1, 8'h1c, 32'hffffffff, 4'hf);
		rd(8'h1c, 32'h0, '1);
		wb(1'b1, 8'h0c, 32'hffffffff, 4'hf);
		wb(1'b1, 8'h10, 32'hffffffff, 4'hf);
		wb(1'b1, 8'h18, 32'hffffffff, 4'hf);
		rd(8'h0c, 32'h00008fff, '1);
		rd(8'h10, 32'h0000003f, '1);
		rd(8'h18, 32'h01ff01ff, '1);
		wb(1'b1, 8'h0c, 32'h0, 4'hf);
		for (i = 0; i < 6; i++)
		begin
			d = i == 0 ? 32'h1c000000 : i == 1 ? 32'h14000000 : i == 2 ? 32'h0 : $random(seed);
			qp.push_back(~d[31:26]);
			wb(1'b1, 8'h00, d, 4'hf);
			rd(8'h00, d, '1);
		end
		wb(1'b1, 8'h00, 32'h0, 4'hf);
		wb(1'b1, 8'h00, 32'hffffffff, 4'h8);
		rd(8'h00, 32'hff000000, '1);
		wb(1'b1, 8'h00, 32'h1c000000, 4'hf);
		wb(1'b1, 8'h04, 32'h00008002, 4'hf);
		wb(1'b1, 8'h08, 32'h00000023, 4'hf);
		per(32'd192);
		wb(1'b1, 8'h00, 32'h14000000, 4'hf);
		wb(1'b1, 8'h04, 32'h00000001, 4'hf);
		wb(1'b1, 8'h08, 32'h00000021, 4'hf);
		en_h <= 1'b1;
		per(32'd80);
		en_h <= 1'b0;
		en_b <= 1'b1;
		wb(1'b1, 8'h00, 32'h0, 4'hf);
		wb(1'b1, 8'h04, 32'h0, 4'hf);
		wb(1'b1, 8'h14, 32'h3, 4'hf);
		repeat (1500) @(posedge clk_i);
		rd(8'h14, 32'h0, 32'h3);
		wb(1'b1, 8'h04, 32'h00008001, 4'hf);
		per(32'd64);
		repeat (1500) @(posedge clk_i);
		rd(8'h14, 32'h1, 32'h3);
		repeat (3) @(posedge clk_i);
		complete_run();
	end
endmodule
